/* File: logic/dcw3_pkg.sv */
`default_nettype none
package dcw3_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int unsigned CFG_WIDTH = 32;
  localparam int unsigned BIT_USB_ID_OWNER = 30;
  localparam int unsigned BIT_PIN_REMAP_LOCK = 29;
  localparam int unsigned BIT_MOD_DISABLE_LOCK = 28;
  localparam int unsigned BIT_PERM_GROUP_LOCK = 27;
  localparam int unsigned BIT_ETH_PIN_SET = 25;
  localparam int unsigned BIT_ETH_MEDIA_IF = 24;
  localparam int unsigned USER_ID_LSB = 0;
  localparam int unsigned USER_ID_WIDTH = 16;

  // Reserved positions 31, 26 and 23:16, expected programmed as ones
  localparam logic [31:0] RESERVED_MASK = 32'h84ff_0000;

  // Word value held before the load, an erased array reads all ones
  localparam logic [31:0] CFG_RESET_VALUE = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // One-way lock domains
  // ----------------------------------------------------------------
  localparam int unsigned LOCK_COUNT = 3;
  localparam int unsigned LOCK_PIN_REMAP = 0;
  localparam int unsigned LOCK_MOD_DISABLE = 1;
  localparam int unsigned LOCK_PERM_GROUP = 2;

  typedef enum logic {
    DCW3_LOAD,
    DCW3_RUN
  } dcw3_load_state_type;

endpackage
`default_nettype wire

/* File: logic/dcw3_lock_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Change request and answer between the top and one lock unit
interface dcw3_lock_if;
  logic req;
  logic one_way;
  logic accept;
  logic locked;
  modport ctrl (output req, output one_way, input accept, input locked);
  modport unit (input req, input one_way, output accept, output locked);
endinterface
`default_nettype wire

/* File: logic/dcw3_one_way_lock.sv */
`timescale 1ns/100ps
`default_nettype none
module dcw3_one_way_lock
  import dcw3_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  dcw3_lock_if.unit lk
);

  logic accept_reg;
  logic accept_next;
  logic locked_reg;
  logic locked_next;

  // ----------------------------------------------------------------
  // Change gating
  // ----------------------------------------------------------------

  // A change is taken while open; with one-way set the first one closes it
  always_comb begin
    accept_next = lk.req & ~locked_reg;
    locked_next = locked_reg | (lk.req & ~locked_reg & lk.one_way);
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accept_reg <= 1'b0;
      locked_reg <= 1'b0;
    end else if (clk_en) begin
      accept_reg <= accept_next;
      locked_reg <= locked_next;
    end
  end

  assign lk.accept = accept_reg;
  assign lk.locked = locked_reg;

endmodule
`default_nettype wire

/* File: logic/dcw3_top.sv */
// Overview of operation
// - Bit 30 set gives the USB id pin to USB; clear gives it to ports.
// - USB module disable set forces the USB id pin back to port control.
// - Bit 29 set permits one pin remap change; clear permits many.
// - Bit 28 set permits one module-disable change; clear permits many.
// - Bit 27 set permits one permission group change; clear permits many.
// - Bit 25 picks default Ethernet pins when set, alternate pins when clear.
// - Bit 24 selects MII when set and RMII when clear.
// - Bits 15 to 0 hold a user identifier readable over JTAG.
`timescale 1ns/100ps
`default_nettype none
module dcw3_top
  import dcw3_pkg::*;
#(
  parameter bit HAS_ALT_ETH_PINS = 1'b1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [CFG_WIDTH-1:0] nvm_word,
  input wire logic usb_module_disable,
  input wire logic [LOCK_COUNT-1:0] change_req,
  input wire logic jtag_id_rd,
  output logic cfg_loaded,
  output logic usb_id_pin_owner_sel,
  output logic ethernet_pin_set_sel,
  output logic ethernet_media_if_type_sel,
  output logic [LOCK_COUNT-1:0] change_accept,
  output logic [LOCK_COUNT-1:0] change_locked,
  output logic [USER_ID_WIDTH-1:0] jtag_id_data,
  output logic jtag_id_valid,
  output logic reserved_err
);

  dcw3_load_state_type state_reg;
  dcw3_load_state_type state_next;
  logic [CFG_WIDTH-1:0] word_reg;
  logic [CFG_WIDTH-1:0] word_next;
  logic usb_owner_reg;
  logic usb_owner_next;
  logic eth_pin_reg;
  logic eth_pin_next;
  logic eth_media_reg;
  logic eth_media_next;
  logic rsv_err_reg;
  logic rsv_err_next;
  logic [USER_ID_WIDTH-1:0] id_data_reg;
  logic [USER_ID_WIDTH-1:0] id_data_next;
  logic id_valid_reg;
  logic id_valid_next;
  logic [LOCK_COUNT-1:0] one_way_bits;
  logic loaded_reg;
  logic loaded_next;

  // Lock bit of a given domain from the held word
  function automatic logic lock_bit(input logic [CFG_WIDTH-1:0] w, input int unsigned idx);
    logic b;
    b = 1'b0;
    if (idx == LOCK_PIN_REMAP) begin
      b = w[BIT_PIN_REMAP_LOCK];
    end else if (idx == LOCK_MOD_DISABLE) begin
      b = w[BIT_MOD_DISABLE_LOCK];
    end else if (idx == LOCK_PERM_GROUP) begin
      b = w[BIT_PERM_GROUP_LOCK];
    end
    return b;
  endfunction

  // True once the word has been captured and decoding may start
  function automatic logic word_ready(input dcw3_load_state_type s);
    return s == DCW3_RUN;
  endfunction

  // ----------------------------------------------------------------
  // Word load after reset
  // ----------------------------------------------------------------

  // Capture once on the first enabled edge after release, then hold
  always_comb begin
    state_next = state_reg;
    word_next = word_reg;
    case (state_reg)
      DCW3_LOAD: begin
        word_next = nvm_word;
        state_next = DCW3_RUN;
      end
      DCW3_RUN: begin
        state_next = DCW3_RUN;
      end
      default: begin
        state_next = DCW3_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DCW3_LOAD;
      word_reg <= CFG_RESET_VALUE;
    end else if (clk_en) begin
      state_reg <= state_next;
      word_reg <= word_next;
    end
  end

  // ----------------------------------------------------------------
  // Load status
  // ----------------------------------------------------------------

  // Own flop that follows the load state, so the status pin is registered
  always_comb begin
    loaded_next = word_ready(state_next);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_reg <= 1'b0;
    end else if (clk_en) begin
      loaded_reg <= loaded_next;
    end
  end

  // ----------------------------------------------------------------
  // USB id pin ownership
  // ----------------------------------------------------------------

  // Owner follows the word, module disable wins, ports own it before load
  always_comb begin
    usb_owner_next = 1'b0;
    if (word_ready(state_reg)) begin
      usb_owner_next = word_reg[BIT_USB_ID_OWNER] & ~usb_module_disable;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      usb_owner_reg <= 1'b0;
    end else if (clk_en) begin
      usb_owner_reg <= usb_owner_next;
    end
  end

  // ----------------------------------------------------------------
  // Ethernet selects and reserved check
  // ----------------------------------------------------------------

  // Decoded levels, held at defaults until the word is in
  always_comb begin
    eth_pin_next = 1'b1;
    eth_media_next = 1'b0;
    rsv_err_next = 1'b0;
    if (word_ready(state_reg)) begin
      eth_pin_next = word_reg[BIT_ETH_PIN_SET] | ~HAS_ALT_ETH_PINS;
      eth_media_next = word_reg[BIT_ETH_MEDIA_IF];
      rsv_err_next = (word_reg & RESERVED_MASK) != RESERVED_MASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eth_pin_reg <= 1'b1;
      eth_media_reg <= 1'b0;
      rsv_err_reg <= 1'b0;
    end else if (clk_en) begin
      eth_pin_reg <= eth_pin_next;
      eth_media_reg <= eth_media_next;
      rsv_err_reg <= rsv_err_next;
    end
  end

  // ----------------------------------------------------------------
  // User identifier read over the debug port
  // ----------------------------------------------------------------

  // One-cycle answer; data stays until the next read
  always_comb begin
    id_valid_next = jtag_id_rd;
    id_data_next = id_data_reg;
    if (jtag_id_rd) begin
      id_data_next = word_reg[USER_ID_LSB +: USER_ID_WIDTH];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      id_valid_reg <= 1'b0;
      id_data_reg <= '0;
    end else if (clk_en) begin
      id_valid_reg <= id_valid_next;
      id_data_reg <= id_data_next;
    end
  end

  // ----------------------------------------------------------------
  // One-way lock domains
  // ----------------------------------------------------------------

  // Requests before the word is loaded are refused outright
  generate
    for (genvar i = 0; i < LOCK_COUNT; i++) begin : g_lock
      dcw3_lock_if lk ();
      assign one_way_bits[i] = lock_bit(word_reg, i);
      assign lk.one_way = one_way_bits[i];
      assign lk.req = change_req[i] & word_ready(state_reg);
      dcw3_one_way_lock u_lock (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .lk(lk.unit)
      );
      assign change_accept[i] = lk.accept;
      assign change_locked[i] = lk.locked;
    end
  endgenerate

  // Outputs straight from registers
  assign cfg_loaded = loaded_reg;
  assign usb_id_pin_owner_sel = usb_owner_reg;
  assign ethernet_pin_set_sel = eth_pin_reg;
  assign ethernet_media_if_type_sel = eth_media_reg;
  assign jtag_id_data = id_data_reg;
  assign jtag_id_valid = id_valid_reg;
  assign reserved_err = rsv_err_reg;

endmodule
`default_nettype wire

/* File: verification/dcw3_prog_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dcw3_prog_model
  import dcw3_pkg::*;
(
  input wire logic [5:0] flags,
  input wire logic [15:0] user_id,
  input wire logic bad,
  output logic [CFG_WIDTH-1:0] word
);
  // Burnt word, reserved places are ones unless bad asks for a fault
  assign word = {1'b1, flags[5:2], ~bad, flags[1:0], 8'hff, user_id};
endmodule
`default_nettype wire

/* File: verification/dcw3_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module dcw3_checker
  import dcw3_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [CFG_WIDTH-1:0] nvm_word,
  input wire logic usb_module_disable,
  input wire logic [LOCK_COUNT-1:0] change_req,
  input wire logic cfg_loaded,
  input wire logic usb_id_pin_owner_sel,
  input wire logic ethernet_media_if_type_sel,
  input wire logic [LOCK_COUNT-1:0] change_accept,
  input wire logic [LOCK_COUNT-1:0] change_locked
);
  logic [CFG_WIDTH-1:0] w_reg;
  logic run;
  // Shadow of the word taken at the first enabled edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) w_reg <= CFG_RESET_VALUE;
    else if (clk_en && !cfg_loaded) w_reg <= nvm_word;
  end
  assign run = clk_en && cfg_loaded;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_usb_owner:
    assert property (run |=> usb_id_pin_owner_sel == (w_reg[30] && !$past(usb_module_disable)))
    else $error("usb owner");
  a_media_map: assert property (run |=> ethernet_media_if_type_sel == w_reg[24])
    else $error("media type");
  a_remap_first:
    assert property (run && change_req[0] && !change_locked[0]
      |=> change_accept[0] && change_locked[0] == w_reg[29]) else $error("remap lock");
  a_mod_take: assert property (run && change_req[1] && !change_locked[1] |=> change_accept[1])
    else $error("mod take");
  a_mod_refuse: assert property (clk_en && change_locked[1] |=> !change_accept[1])
    else $error("mod refuse");
  a_perm_once:
    assert property (run && change_req[2] && !change_locked[2]
      |=> (change_locked[2] == w_reg[27]) [*2]) else $error("perm lock");
  a_load_hold: assert property (cfg_loaded |=> cfg_loaded)
    else $error("load lost");
  a_no_early: assert property (!cfg_loaded |=> change_accept == 3'h0)
    else $error("early accept");
endmodule
bind dcw3_top dcw3_checker dcw3_checker_i (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
  .nvm_word(nvm_word), .usb_module_disable(usb_module_disable), .change_req(change_req),
  .cfg_loaded(cfg_loaded), .usb_id_pin_owner_sel(usb_id_pin_owner_sel),
  .ethernet_media_if_type_sel(ethernet_media_if_type_sel), .change_accept(change_accept),
  .change_locked(change_locked));
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench import dcw3_pkg::*;;
  logic clk, arst_n, clk_en, dis, rd, bad, ld, own, pin, med, resv, idv;
  logic [2:0] req, acc, lck;
  logic [15:0] idd;
  logic [31:0] word, seed;
  logic [15:0] q[$];
  int fails = 0;
  int n_compared = 0;
  dcw3_prog_model dcw3_prog_model_i (.flags(seed[5:0] ^ {6{ld}}), .user_id(seed[31:16]),
    .bad(bad), .word(word));
  dcw3_top dcw3_top_i (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .nvm_word(word),
    .usb_module_disable(dis), .change_req(req), .jtag_id_rd(rd), .cfg_loaded(ld),
    .usb_id_pin_owner_sel(own), .ethernet_pin_set_sel(pin),
    .ethernet_media_if_type_sel(med), .change_accept(acc), .change_locked(lck),
    .jtag_id_data(idd), .jtag_id_valid(idv), .reserved_err(resv));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic a, input logic e);
    n_compared++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: got %b want %b", $time, a, e);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #10 clk = ~clk;
  // Takes the oldest noted id whenever a read answer shows
  always @(posedge clk) begin
    if (idv === 1'b1) begin
      chk(q.size() > 0 && idd === q[0], 1'b1);
      if (q.size() > 0) void'(q.pop_front());
    end
  end
  // Loads a random word after each reset, its six flag bits flip once loaded
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    {dis, rd, bad, req} = 6'h00;
    seed = 32'h0001_6bbb;
    for (int t = 0; t < 4; t++) begin
      seed = lfsr(seed);
      bad = (t == 3);
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      clk_en = 1'b0;
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk(ld, 1'b0);
      clk_en = 1'b1;
      for (int k = 0; k < 8 && ld !== 1'b1; k++) @(negedge clk);
      chk(ld, 1'b1);
      if (ld !== 1'b1) break;
      repeat (2) @(negedge clk);
      chk(own, seed[5]);
      chk(pin, seed[1]);
      chk(med, seed[0]);
      chk(resv, bad);
      clk_en = 1'b0;
      dis = 1'b1;
      @(negedge clk);
      chk(own, seed[5]);
      clk_en = 1'b1;
      @(negedge clk);
      chk(own, 1'b0);
      dis = 1'b0;
      rd = 1'b1;
      q.push_back(seed[31:16]);
      @(negedge clk);
      q.push_back(seed[31:16]);
      @(negedge clk);
      rd = 1'b0;
      chk(own, seed[5]);
      for (int i = 0; i < 3; i++) begin
        req[i] = 1'b1;
        @(negedge clk);
        chk(acc[i], 1'b1);
        chk(lck[i], seed[4-i]);
        @(negedge clk);
        chk(acc[i], ~seed[4-i]);
        req[i] = 1'b0;
      end
    end
    @(negedge clk);
    chk(q.size() == 0, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
